// ===== verilog/err_report.sv
// Command error detection, stop-on-first-error and error/status reporting
`timescale 1ns/10ps
module err_report
   import err_report_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_cmd_write,
   input  wire logic [7:0] i_cmd_code,
   input  wire logic [7:0] i_precomp,
   input  wire fault_s     i_fault,
   input  wire logic       i_op_done,
   input  wire host_rd_s   i_host_rd,
   input  wire logic [7:0] i_reg_rdata,
   output logic [7:0]      o_error,
   output logic [7:0]      o_status,
   output logic [7:0]      o_host_rdata,
   output logic            o_lookahead_en,
   output logic            o_op_start,
   output logic            o_op_abort,
   output logic            o_cmd_done
);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_RUN   = 2'b11,
      ST_END   = 2'b10
   } state_e;

   state_e       state_reg, state_next;
   cmd_class_e   cls_reg, cls_next;
   logic [7:0]   error_reg, error_next;
   logic [7:0]   status_reg, status_next;
   logic [7:0]   rdata_reg, rdata_next;
   logic         look_reg, look_next;
   logic         start_reg, start_next;
   logic         abort_reg, abort_next;
   logic         done_reg, done_next;
   logic [7:0]   code_reg;
   logic [7:0]   precomp_reg;

   // Map command codes to error-report classes
   function automatic cmd_class_e decode_class(input logic [7:0] code);
      cmd_class_e c;
      c = CLS_INVAL;
      if (code[7:4] == CMD_RECAL[7:4])
         c = CLS_RECAL;
      else if (code == CMD_READ_SEC || code == CMD_READ_SEC + 8'h01 ||
               code == CMD_READ_VER || code == CMD_READ_VER + 8'h01 ||
               code == CMD_READ_MULT)
         c = CLS_READ;
      else if (code == CMD_WRITE_SEC || code == CMD_WRITE_SEC + 8'h01 ||
               code == CMD_WRITE_LONG || code == CMD_WRITE_LONG + 8'h01 ||
               code == CMD_READ_LONG || code == CMD_READ_LONG + 8'h01 ||
               code == CMD_WRITE_MULT)
         c = CLS_WRITE;
      else if (code == CMD_FORMAT)
         c = CLS_FORMAT;
      else if (code[7:4] == CMD_SEEK[7:4])
         c = CLS_FMTSEEK;
      else if (code == CMD_BUF_MODE)
         c = CLS_BUFMODE;
      else if (code == CMD_DIAG || code == CMD_INIT_PARMS ||
               code == CMD_SET_MULT || code == CMD_READ_BUF ||
               code == CMD_WRITE_BUF || code == CMD_IDENTIFY)
         c = CLS_MISC;
      return c;
   endfunction

   // Pack allowed faults into the error register layout
   function automatic logic [7:0] pack_err(input fault_s f);
      logic [7:0] e;
      e = ZERO_BYTE;
      e[ERR_BIT_BAD_BLOCK] = f.bad_block_flag;
      e[ERR_BIT_BAD_DATA]  = f.uncorrectable_data_flag;
      e[ERR_BIT_ID_MISS]   = f.sector_id_missing_flag;
      e[ERR_BIT_TRK0]      = f.track_zero_missing_flag;
      e[ERR_BIT_FIX_DATA]  = f.corrected_data_flag;
      e[ERR_BIT_NOT_READY] = f.drive_not_ready_flag;
      return e;
   endfunction

   fault_s     gated;
   logic [7:0] err_bits;
   logic       any_err;
   logic       pre_abort;
   logic       busy;
   logic       bufmode_ok;

   // Fault gating by the class of the running command
   err_allow_mask u_mask (
      .i_cls   (cls_reg),
      .i_fault (i_fault),
      .o_fault (gated)
   );

   // Decode of fault and abort conditions
   assign err_bits   = pack_err(gated);
   assign any_err    = (err_bits != ZERO_BYTE) || gated.write_fault_flag ||
                       gated.seek_complete_missing_flag;
   assign bufmode_ok = (precomp_reg == BUFMODE_ENABLE) ||
                       (precomp_reg == BUFMODE_DISABLE);
   assign pre_abort  = (cls_reg == CLS_INVAL) || (cls_reg == CLS_MISC) ||
                       (cls_reg == CLS_FORMAT) ||
                       (cls_reg == CLS_BUFMODE && !bufmode_ok);
   assign busy       = status_reg[STS_BIT_BUSY];

   // Next-state and register logic
   always_comb begin
      state_next  = state_reg;
      cls_next    = cls_reg;
      error_next  = error_reg;
      status_next = status_reg;
      look_next   = look_reg;
      start_next  = 1'b0;
      abort_next  = 1'b0;
      done_next   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (i_cmd_write) begin
               cls_next    = decode_class(i_cmd_code);
               status_next = STS_RESET_VAL;
               status_next[STS_BIT_BUSY] = 1'b1;
               error_next  = ZERO_BYTE;
               state_next  = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (pre_abort) begin
               error_next[ERR_BIT_ABORT] = 1'b1;
               status_next[STS_BIT_ERR]  = 1'b1;
               state_next = ST_END;
            end else if (cls_reg == CLS_BUFMODE) begin
               look_next  = (precomp_reg == BUFMODE_ENABLE);
               state_next = ST_END;
            end else begin
               start_next = 1'b1;
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_err) begin
               error_next  = err_bits;
               status_next[STS_BIT_WFAULT] = gated.write_fault_flag;
               status_next[STS_BIT_SEEK_OK] =
                  !gated.seek_complete_missing_flag;
               status_next[STS_BIT_ERR] = 1'b1;
               abort_next  = 1'b1;
               state_next  = ST_END;
            end else if (i_op_done) begin
               status_next[STS_BIT_SEEK_OK] = 1'b1;
               state_next = ST_END;
            end
         end
         ST_END: begin
            status_next[STS_BIT_BUSY] = 1'b0;
            status_next[STS_BIT_READY] = 1'b1;
            done_next  = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // Host read path: status substitutes for any register while busy
   assign rdata_next = (!i_host_rd.rd) ? rdata_reg :
                       (busy || i_host_rd.addr == TF_IDX_STATUS) ?
                          status_reg :
                       (i_host_rd.addr == TF_IDX_ERROR) ? error_reg :
                       i_reg_rdata;

   // Command latches
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         code_reg    <= ZERO_BYTE;
         precomp_reg <= ZERO_BYTE;
      end else if (state_reg == ST_IDLE && i_cmd_write) begin
         code_reg    <= i_cmd_code;
         precomp_reg <= i_precomp;
      end
   end

   // State registers; reset loads error 01, not busy, no done pulse
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_reg  <= ST_IDLE;
         cls_reg    <= CLS_INVAL;
         error_reg  <= ERR_RESET_VAL;
         status_reg <= STS_RESET_VAL;
         rdata_reg  <= ZERO_BYTE;
         look_reg   <= 1'b1;
         start_reg  <= 1'b0;
         abort_reg  <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cls_reg    <= cls_next;
         error_reg  <= error_next;
         status_reg <= status_next;
         rdata_reg  <= rdata_next;
         look_reg   <= look_next;
         start_reg  <= start_next;
         abort_reg  <= abort_next;
         done_reg   <= done_next;
      end
   end

   // Outputs straight from flip-flops
   assign o_error        = error_reg;
   assign o_status       = status_reg;
   assign o_host_rdata   = rdata_reg;
   assign o_lookahead_en = look_reg;
   assign o_op_start     = start_reg;
   assign o_op_abort     = abort_reg;
   assign o_cmd_done     = done_reg;

endmodule

// ===== verilog/err_report_pkg.sv
// Package: command codes, error flag positions, reset values, struct types
package err_report_pkg;

   // Command classes decoded from the command code
   typedef enum logic [2:0] {
      CLS_RECAL  = 3'h0,
      CLS_READ   = 3'h1,
      CLS_WRITE  = 3'h2,
      CLS_FMTSEEK = 3'h3,
      CLS_MISC   = 3'h4,
      CLS_BUFMODE = 3'h5,
      CLS_FORMAT = 3'h6,
      CLS_INVAL  = 3'h7
   } cmd_class_e;

   // Command codes (upper nibble where a group shares it)
   localparam logic [7:0] CMD_RECAL      = 8'h10;
   localparam logic [7:0] CMD_READ_SEC   = 8'h20;
   localparam logic [7:0] CMD_READ_LONG  = 8'h22;
   localparam logic [7:0] CMD_WRITE_SEC  = 8'h30;
   localparam logic [7:0] CMD_WRITE_LONG = 8'h32;
   localparam logic [7:0] CMD_READ_VER   = 8'h40;
   localparam logic [7:0] CMD_FORMAT     = 8'h50;
   localparam logic [7:0] CMD_SEEK       = 8'h70;
   localparam logic [7:0] CMD_DIAG       = 8'h90;
   localparam logic [7:0] CMD_INIT_PARMS = 8'h91;
   localparam logic [7:0] CMD_READ_BUF   = 8'he4;
   localparam logic [7:0] CMD_WRITE_BUF  = 8'he8;
   localparam logic [7:0] CMD_IDENTIFY   = 8'hec;
   localparam logic [7:0] CMD_BUF_MODE   = 8'hef;
   localparam logic [7:0] CMD_READ_MULT  = 8'hc4;
   localparam logic [7:0] CMD_WRITE_MULT = 8'hc5;
   localparam logic [7:0] CMD_SET_MULT   = 8'hc6;

   // Buffer-mode precompensation codes
   localparam logic [7:0] BUFMODE_ENABLE  = 8'haa;
   localparam logic [7:0] BUFMODE_DISABLE = 8'h55;

   // Error register bit positions
   localparam int ERR_BIT_ADDR_MARK = 0;
   localparam int ERR_BIT_TRK0      = 1;
   localparam int ERR_BIT_ABORT     = 2;
   localparam int ERR_BIT_NOT_READY = 3;
   localparam int ERR_BIT_ID_MISS   = 4;
   localparam int ERR_BIT_FIX_DATA  = 5;
   localparam int ERR_BIT_BAD_DATA  = 6;
   localparam int ERR_BIT_BAD_BLOCK = 7;
   localparam int ERR_W             = 8;

   // Status register bit positions
   localparam int STS_BIT_ERR     = 0;
   localparam int STS_BIT_SEEK_OK = 4;
   localparam int STS_BIT_WFAULT  = 5;
   localparam int STS_BIT_READY   = 6;
   localparam int STS_BIT_BUSY    = 7;

   // Reset values
   localparam logic [7:0] ERR_RESET_VAL = 8'h01;
   localparam logic [7:0] STS_RESET_VAL = 8'h00;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   // Fault reports from the drive mechanics and data path
   typedef struct packed {
      logic bad_block_flag;
      logic uncorrectable_data_flag;
      logic sector_id_missing_flag;
      logic track_zero_missing_flag;
      logic drive_not_ready_flag;
      logic write_fault_flag;
      logic seek_complete_missing_flag;
      logic corrected_data_flag;
   } fault_s;

   // Host register-read request
   typedef struct packed {
      logic       rd;
      logic [2:0] addr;
   } host_rd_s;

   // Host register read indices for error and status
   localparam logic [2:0] TF_IDX_ERROR  = 3'h1;
   localparam logic [2:0] TF_IDX_STATUS = 3'h7;

endpackage

// ===== verilog/err_allow_mask.sv
// Per command class, the set of fault flags allowed to reach the host
`timescale 1ns/10ps
module err_allow_mask
   import err_report_pkg::*;
(
   input  wire cmd_class_e i_cls,
   input  wire fault_s     i_fault,
   output fault_s          o_fault
);

   fault_s allow;

   // Which flags each command class may report
   always_comb begin
      allow = '0;
      case (i_cls)
         CLS_RECAL: begin
            allow.track_zero_missing_flag    = 1'b1;
            allow.drive_not_ready_flag       = 1'b1;
            allow.write_fault_flag           = 1'b1;
            allow.seek_complete_missing_flag = 1'b1;
         end
         CLS_READ: begin
            allow.bad_block_flag             = 1'b1;
            allow.uncorrectable_data_flag    = 1'b1;
            allow.sector_id_missing_flag     = 1'b1;
            allow.drive_not_ready_flag       = 1'b1;
            allow.write_fault_flag           = 1'b1;
            allow.seek_complete_missing_flag = 1'b1;
            allow.corrected_data_flag        = 1'b1;
         end
         CLS_WRITE: begin
            allow.bad_block_flag             = 1'b1;
            allow.sector_id_missing_flag     = 1'b1;
            allow.drive_not_ready_flag       = 1'b1;
            allow.write_fault_flag           = 1'b1;
            allow.seek_complete_missing_flag = 1'b1;
         end
         CLS_FMTSEEK, CLS_FORMAT: begin
            allow.sector_id_missing_flag     = 1'b1;
            allow.drive_not_ready_flag       = 1'b1;
            allow.write_fault_flag           = 1'b1;
            allow.seek_complete_missing_flag = 1'b1;
         end
         default: begin
            allow = '0;
         end
      endcase
   end

   // Gate incoming faults
   assign o_fault = i_fault & allow;

endmodule

// ===== tb/err_report_properties.sv
// Checker: timing and flag relations at the error report ports
`timescale 1ns/10ps
module err_report_properties
   import err_report_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_cmd_write,
   input  wire logic [7:0] i_cmd_code,
   input  wire logic [7:0] i_precomp,
   input  wire host_rd_s   i_host_rd,
   input  wire logic [7:0] o_error,
   input  wire logic [7:0] o_status,
   input  wire logic [7:0] o_host_rdata,
   input  wire logic       o_op_start,
   input  wire logic       o_op_abort,
   input  wire logic       o_cmd_done
);
   default clocking dcb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // Code class decode for antecedents
   wire misc_hit = i_cmd_code inside {CMD_DIAG, CMD_INIT_PARMS, CMD_SET_MULT,
      CMD_READ_BUF, CMD_WRITE_BUF, CMD_IDENTIFY};
   wire wr_hit = i_cmd_code inside {CMD_WRITE_SEC, CMD_WRITE_LONG,
      CMD_WRITE_MULT, CMD_READ_LONG};
   wire bad_bm = i_cmd_code == CMD_BUF_MODE &&
      !(i_precomp inside {BUFMODE_ENABLE, BUFMODE_DISABLE});
   // Command accepted while idle
   sequence s_take(logic hit);
      i_cmd_write && !o_status[7] && hit;
   endsequence
   // Masked flags stay clear until completion
   sequence s_end(logic [7:0] m);
      ((o_error & m) == 8'h00) throughout (##[1:60] o_cmd_done);
   endsequence
   a_busy_on_take: assert property (s_take(1'b1) |=> o_status[7])
      else $error("busy not set after command");
   a_reset_values: assert property ($fell(i_rst) |->
      o_error == 8'h01 && o_status == 8'h00)
      else $error("bad values after reset");
   a_error_sets_err: assert property (o_cmd_done && o_error[7:1] != 7'h00
      |-> o_status[0])
      else $error("error flag without status error bit");
   a_abort_ends_cmd: assert property (o_op_abort |-> o_status[0]
      ##1 (o_cmd_done && !o_status[7]))
      else $error("command not ended after fault");
   a_misc_abort_only: assert property (s_take(misc_hit) |->
      ##2 (o_error == 8'h04 && o_status[0]) ##1 o_cmd_done)
      else $error("misc command not aborted alone");
   a_format_refused: assert property (s_take(i_cmd_code == CMD_FORMAT) |->
      !o_op_start throughout (##[2:3] (o_cmd_done && o_error[2])))
      else $error("format reached the mechanics");
   a_bufmode_bad: assert property (s_take(bad_bm) |->
      ##2 o_error[2] ##1 o_cmd_done)
      else $error("bad buffer mode not aborted");
   a_write_no_data: assert property (s_take(wr_hit) |->
      ##2 s_end(8'h60))
      else $error("data error flag on write class");
   a_seek_no_bbk: assert property (s_take(i_cmd_code == CMD_SEEK) |->
      ##2 s_end(8'he2))
      else $error("illegal flag on seek");
   a_recal_no_data: assert property (s_take(i_cmd_code == CMD_RECAL) |->
      ##2 s_end(8'hf0))
      else $error("illegal flag on recalibrate");
   a_busy_reads_status: assert property (i_host_rd.rd && o_status[7] |=>
      o_host_rdata == $past(o_status))
      else $error("busy read did not return status");
endmodule
bind err_report err_report_properties u_props (.i_sys_clk(i_sys_clk),
   .i_rst(i_rst), .i_cmd_write(i_cmd_write), .i_cmd_code(i_cmd_code),
   .i_precomp(i_precomp), .i_host_rd(i_host_rd), .o_error(o_error),
   .o_status(o_status), .o_host_rdata(o_host_rdata),
   .o_op_start(o_op_start), .o_op_abort(o_op_abort),
   .o_cmd_done(o_cmd_done));

// ===== tb/mech_model.sv
// Drive mechanics model: answers an operation start with fault or done
`timescale 1ns/10ps
module mech_model
   import err_report_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_op_start,
   input  wire logic       i_op_abort,
   input  wire logic       i_cmd_done,
   input  wire fault_s     i_req,
   input  wire logic [7:0] i_delay,
   output fault_s          o_fault = '0,
   output logic            o_op_done = 1'b0
);
   int cnt = 0;
   // Fault after the delay; completion if nobody stops the operation
   always @(negedge i_sys_clk) begin
      if (i_rst || i_op_abort || i_cmd_done) begin
         cnt       <= 0;
         o_fault   <= '0;
         o_op_done <= 1'b0;
      end else if (i_op_start) begin
         cnt       <= 1;
         o_op_done <= 1'b0;
      end else if (cnt == int'(i_delay) + 4) begin
         cnt       <= 0;
         o_fault   <= '0;
         o_op_done <= 1'b1;
      end else begin
         o_op_done <= 1'b0;
         if (cnt > 0) cnt <= cnt + 1;
         if (cnt == int'(i_delay) + 1) o_fault <= i_req;
      end
   end
endmodule

// ===== tb/test_err_report.sv
// Testbench: command error reporting sequences
`timescale 1ns/10ps
module test_err_report;
   import err_report_pkg::*;
   logic       clk = 0, rst = 1, cmd_wr = 0, op_done, la, start, op_ab, done;
   logic [7:0] code = 0, pre = 0, reg_rd = 8'h3c, dly = 8'h02;
   logic [7:0] err, sts, rdata;
   fault_s     flt, req = '0;
   host_rd_s   hrd = '0;
   int         n_fail = 0, samples_checked = 0, cyc = 0;
   logic [7:0] mc[7] = '{CMD_DIAG, CMD_INIT_PARMS, CMD_SET_MULT,
      CMD_READ_BUF, CMD_WRITE_BUF, CMD_IDENTIFY, CMD_BUF_MODE};
   // Block under test, and a mechanics model driving its fault and done lines
   err_report dut (.i_sys_clk(clk), .i_rst(rst), .i_cmd_write(cmd_wr),
      .i_cmd_code(code), .i_precomp(pre), .i_fault(flt),
      .i_op_done(op_done), .i_host_rd(hrd), .i_reg_rdata(reg_rd),
      .o_error(err), .o_status(sts), .o_host_rdata(rdata),
      .o_lookahead_en(la), .o_op_start(start), .o_op_abort(op_ab),
      .o_cmd_done(done));
   mech_model mdl (.i_sys_clk(clk), .i_rst(rst), .i_op_start(start),
      .i_op_abort(op_ab), .i_cmd_done(done), .i_req(req), .i_delay(dly),
      .o_fault(flt), .o_op_done(op_done));
   initial forever #25 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   task chk(string nm, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One command: code, precomp, fault, error byte, status error, run kind
   task cmd(logic [7:0] c, p, f, e, logic x, int r);
      int i;
      logic ab, st;
      @(negedge clk);
      code = c;
      pre = p;
      req = fault_s'(f);
      cmd_wr = 1;
      @(negedge clk);
      cmd_wr = 0;
      ab = 0;
      st = 0;
      i = 0;
      while (done !== 1'b1 && i < 100) begin
         @(posedge clk);
         #1;
         ab |= op_ab === 1'b1;
         st |= start === 1'b1;
         i++;
      end
      chk("done", 8'(done), 8'h01);
      chk("error", err, e);
      chk("sts_err", 8'(sts[0]), 8'(x));
      chk("busy", 8'(sts[7]), 8'h00);
      if (r < 2) chk("start", 8'(st), 8'(r));
      if (r < 2) chk("abort", 8'(ab), 8'(x && r == 1));
   endtask
   // Host read of one decoded register index
   task rd(logic [2:0] a, logic [7:0] e);
      @(negedge clk);
      hrd = '{1'b1, a};
      @(negedge clk);
      hrd = '0;
      chk("rdata", rdata, e);
   endtask
   task do_reset;
      @(negedge clk);
      rst = 1;
      repeat (4) @(negedge clk);
      rst = 0;
      chk("rst_err", err, ERR_RESET_VAL);
      chk("rst_sts", sts, 8'h00);
      chk("rst_la", 8'(la), 8'h01);
   endtask
   initial begin
      do_reset();
      foreach (mc[i]) cmd(mc[i], 8'h12, 8'h00, 8'h04, 1, 0);
      cmd(8'hff, 8'h00, 8'h00, 8'h04, 1, 0);
      cmd(CMD_FORMAT, 8'h00, 8'h00, 8'h04, 1, 0);
      cmd(CMD_BUF_MODE, BUFMODE_DISABLE, 8'h00, 8'h00, 0, 2);
      chk("la", 8'(la), 8'h00);
      cmd(CMD_BUF_MODE, BUFMODE_ENABLE, 8'h00, 8'h00, 0, 2);
      chk("la", 8'(la), 8'h01);
      cmd(CMD_READ_SEC, 8'h00, 8'h40, 8'h40, 1, 1);
      cmd(CMD_READ_VER, 8'h00, 8'h01, 8'h20, 1, 1);
      cmd(CMD_READ_MULT, 8'h00, 8'h80, 8'h80, 1, 1);
      cmd(CMD_READ_SEC, 8'h00, 8'h20, 8'h10, 1, 1);
      cmd(CMD_READ_SEC, 8'h00, 8'h08, 8'h08, 1, 1);
      cmd(CMD_READ_SEC, 8'h00, 8'h00, 8'h00, 0, 1);
      rd(3'h3, reg_rd);
      dly = 8'h00;
      cmd(CMD_WRITE_SEC, 8'h00, 8'h40, 8'h00, 0, 1);
      cmd(CMD_WRITE_LONG, 8'h00, 8'h01, 8'h00, 0, 1);
      cmd(CMD_READ_LONG, 8'h00, 8'h40, 8'h00, 0, 1);
      cmd(CMD_WRITE_MULT, 8'h00, 8'h80, 8'h80, 1, 1);
      rd(TF_IDX_ERROR, 8'h80);
      cmd(CMD_SEEK, 8'h00, 8'h80, 8'h00, 0, 1);
      cmd(CMD_SEEK, 8'h00, 8'h20, 8'h10, 1, 1);
      cmd(CMD_RECAL, 8'h00, 8'h10, 8'h02, 1, 1);
      cmd(CMD_RECAL, 8'h00, 8'h40, 8'h00, 0, 1);
      cmd(CMD_WRITE_SEC, 8'h00, 8'h04, 8'h00, 1, 1);
      chk("wr_fault", 8'(sts[5]), 8'h01);
      cmd(CMD_READ_SEC, 8'h00, 8'h02, 8'h00, 1, 1);
      chk("seek_done", 8'(sts[4]), 8'h00);
      // Slow read; a read and a second command while busy
      dly = 8'h14;
      fork
         cmd(CMD_READ_SEC, 8'h00, 8'h40, 8'h40, 1, 1);
         begin
            repeat (6) @(negedge clk);
            hrd = '{1'b1, 3'h3};
            cmd_wr = 1;
            code = CMD_DIAG;
            @(negedge clk);
            hrd = '0;
            cmd_wr = 0;
            chk("busy_rd", rdata & 8'h80, 8'h80);
         end
      join
      cmd(CMD_BUF_MODE, BUFMODE_DISABLE, 8'h00, 8'h00, 0, 2);
      do_reset();
      cmd(CMD_DIAG, 8'h00, 8'h00, 8'h04, 1, 0);
      end_sim();
   end
endmodule
